// *** hw/right_route_defs.svh ***
`ifndef RIGHT_ROUTE_DEFS_SVH
`define RIGHT_ROUTE_DEFS_SVH

// ==========================================================
// Register map
`define RT_ADDR_LINE_ONE 8'h16
`define RT_ADDR_LINE_TWO 8'h17
`define RT_RST_LINE_ONE 8'h78
`define RT_RST_LINE_TWO 8'h78
`define RT_RDATA_NONE 8'h00

// ==========================================================
// Field positions; mode and level fields are shared by both registers
`define RT_MODE_BIT 7
`define RT_LEVEL_MSB 6
`define RT_LEVEL_LSB 3
`define RT_POWER_BIT 2
`define RT_BIAS_BIT 2
`define RT_STEP_MSB 1
`define RT_STEP_LSB 0

// Read-only low bits of the second register always hold zero
`define RT_LINE_TWO_WR_MASK 8'hfc
`define RT_LINE_TWO_RO_ZERO 2'h0

// ==========================================================
// Level field codes
`define RT_LEVEL_MAX 4'h8
`define RT_LEVEL_OFF 4'hf
// Attenuation in half-dB units: each code step is 1.5 dB
`define RT_ATTEN_PER_CODE 5'h03
`define RT_ATTEN_NONE 5'h00

`endif

// *** hw/right_route_pkg.sv ***
package right_route_pkg;

    // ==========================================================
    // Gain-stage soft-stepping rate codes
    typedef enum logic [1:0] {
        STEP_EVERY_SAMPLE = 2'b00,
        STEP_EVERY_TWO = 2'b01,
        STEP_OFF_LOW = 2'b10,
        STEP_OFF_HIGH = 2'b11
    } step_rate_type;

    // ==========================================================
    // Pacer phase within a pair of sample periods
    typedef enum logic {
        PHASE_FIRST = 1'b0,
        PHASE_SECOND = 1'b1
    } phase_type;

endpackage

// *** hw/line_input_route.sv ***
`timescale 1ns/1ps
`include "right_route_defs.svh"

module line_input_route (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] level_i,
    output logic connect_o,
    output logic [4:0] atten_o,
    output logic reserved_o
);

    // ==========================================================
    // Level decode
    logic connect_d, connect_q;
    logic [4:0] atten_d, atten_q;
    logic reserved_d, reserved_q;

    // Valid codes connect; reserved codes are treated as open
    always_comb begin
        connect_d = (level_i <= `RT_LEVEL_MAX);
        reserved_d = !connect_d && (level_i != `RT_LEVEL_OFF);
        atten_d = `RT_ATTEN_NONE;
        if (connect_d) begin
            atten_d = 5'({1'b0, level_i} * `RT_ATTEN_PER_CODE);
        end
    end

    // Registered so the analog controls never see a decode glitch
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            connect_q <= 1'b0;
            atten_q <= `RT_ATTEN_NONE;
            reserved_q <= 1'b0;
        end else begin
            connect_q <= connect_d;
            atten_q <= atten_d;
            reserved_q <= reserved_d;
        end
    end

    assign connect_o = connect_q;
    assign atten_o = atten_q;
    assign reserved_o = reserved_q;

endmodule // line_input_route

// *** hw/soft_step_pacer.sv ***
`timescale 1ns/1ps

module soft_step_pacer
    import right_route_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [1:0] rate_i,
    input wire logic sample_tick_i,
    output logic step_o,
    output logic off_o
);

    // ==========================================================
    // Step pacing
    phase_type phase_d, phase_q;
    logic step_d, step_q;
    logic off_d, off_q;

    // Phase only advances in the halved mode, so a later switch
    // to it always starts with a skipped sample
    always_comb begin
        phase_d = PHASE_FIRST;
        step_d = 1'b0;
        off_d = 1'b0;
        case (step_rate_type'(rate_i))
            STEP_EVERY_SAMPLE: begin
                step_d = sample_tick_i;
            end
            STEP_EVERY_TWO: begin
                phase_d = phase_q;
                if (sample_tick_i) begin
                    step_d = (phase_q == PHASE_SECOND);
                    phase_d = (phase_q == PHASE_FIRST) ? PHASE_SECOND
                                                       : PHASE_FIRST;
                end
            end
            default: begin
                off_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_q <= PHASE_FIRST;
            step_q <= 1'b0;
            off_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            step_q <= step_d;
            off_q <= off_d;
        end
    end

    assign step_o = step_q;
    assign off_o = off_q;

endmodule // soft_step_pacer

// *** hw/right_adc_route_regs.sv ***
`timescale 1ns/1ps
`include "right_route_defs.svh"

// Overview of operation
// - First register bit 7 sets input one differential
// - Second register bit 7 sets input two differential
// - Level codes 0-8 give 0 to -12 dB
// - Any valid level code connects input to mixer
// - Code 1111 disconnects input; reset value
// - First register bit 2 powers right channel
// - Bits 1-0 choose soft-step rate or off
// - Second register bit 2 biases unselected inputs
// - Second register bits 1-0 read-only zero

module right_adc_route_regs
    import right_route_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    input wire logic sample_tick_i,
    output logic first_right_line_input_diff_o,
    output logic second_right_line_input_diff_o,
    output logic first_right_line_input_connect_o,
    output logic second_right_line_input_connect_o,
    output logic [4:0] first_right_line_input_atten_o,
    output logic [4:0] second_right_line_input_atten_o,
    output logic level_reserved_o,
    output logic right_adc_power_up_o,
    output logic unselected_bias_o,
    output logic gain_stage_step_o,
    output logic gain_stage_soft_step_off_o
);

    // ==========================================================
    // Elaboration checks
    // Field layout is fixed to byte-wide registers and byte addresses
    if (DATA_W != 8) begin : g_bad_data_w
        $error("DATA_W must be 8");
    end
    if (ADDR_W != 8) begin : g_bad_addr_w
        $error("ADDR_W must be 8");
    end

    // ==========================================================
    // Address decode
    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] target);
        hit = (addr == target);
    endfunction

    logic hit_one, hit_two;

    // Decoded once, used by both write and read paths
    assign hit_one = hit(reg_addr_i, `RT_ADDR_LINE_ONE);
    assign hit_two = hit(reg_addr_i, `RT_ADDR_LINE_TWO);

    // ==========================================================
    // Register storage
    logic [DATA_W-1:0] line_one_d, line_one_q;
    logic [DATA_W-1:0] line_two_d, line_two_q;

    // Writes to unmapped addresses are dropped silently
    always_comb begin
        line_one_d = line_one_q;
        line_two_d = line_two_q;
        if (reg_wr_i && hit_one) begin
            line_one_d = reg_wdata_i;
        end else if (reg_wr_i && hit_two) begin
            // Read-only low bits cannot be set by a careless write
            line_two_d = reg_wdata_i & `RT_LINE_TWO_WR_MASK;
        end
    end

    // Reset leaves both inputs open, channel off, bias off
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_one_q <= `RT_RST_LINE_ONE;
            line_two_q <= `RT_RST_LINE_TWO;
        end else begin
            line_one_q <= line_one_d;
            line_two_q <= line_two_d;
        end
    end

    // ==========================================================
    // Read path
    logic [DATA_W-1:0] rdata_d, rdata_q;

    // Holds the last answer between reads; unmapped reads give zero
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd_i && hit_one) begin
            rdata_d = line_one_q;
        end else if (reg_rd_i && hit_two) begin
            rdata_d = line_two_q;
        end else if (reg_rd_i) begin
            rdata_d = `RT_RDATA_NONE;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= `RT_RDATA_NONE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

    // ==========================================================
    // Field outputs taken straight from the flip-flops
    // Mixed-mode mismatch with the left channel is the host's job
    assign first_right_line_input_diff_o =
        line_one_q[`RT_MODE_BIT];
    assign second_right_line_input_diff_o =
        line_two_q[`RT_MODE_BIT];
    assign right_adc_power_up_o = line_one_q[`RT_POWER_BIT];
    assign unselected_bias_o = line_two_q[`RT_BIAS_BIT];

    // ==========================================================
    // Per-input level decode, one instance per line input
    logic [3:0] level [2];
    logic connect [2];
    logic [4:0] atten [2];
    logic reserved [2];

    assign level[0] = line_one_q[`RT_LEVEL_MSB:`RT_LEVEL_LSB];
    assign level[1] = line_two_q[`RT_LEVEL_MSB:`RT_LEVEL_LSB];

    // Reserved codes leave the input open rather than guess a gain
    for (genvar i = 0; i < 2; i++) begin : g_route
        line_input_route u_route (
            .ref_clk_i(ref_clk_i),
            .rst_n_i(rst_n_i),
            .level_i(level[i]),
            .connect_o(connect[i]),
            .atten_o(atten[i]),
            .reserved_o(reserved[i])
        );
    end

    assign first_right_line_input_connect_o = connect[0];
    assign second_right_line_input_connect_o = connect[1];
    assign first_right_line_input_atten_o = atten[0];
    assign second_right_line_input_atten_o = atten[1];
    // Shows a reserved code got in; storage keeps it for readback
    assign level_reserved_o = reserved[0] | reserved[1];

    // ==========================================================
    // Gain-stage soft-stepping
    soft_step_pacer u_pacer (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .rate_i(line_one_q[`RT_STEP_MSB:`RT_STEP_LSB]),
        .sample_tick_i(sample_tick_i),
        .step_o(gain_stage_step_o),
        .off_o(gain_stage_soft_step_off_o)
    );

    // ==========================================================
    // Checks
    // Mode bit of input one follows a write one cycle later
    chk_mode_one_write: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (reg_wr_i && hit_one) |=>
            first_right_line_input_diff_o ==
            $past(reg_wdata_i[`RT_MODE_BIT]))
        else $error("input one mode does not follow write");

    // Mode bit of input two follows a write one cycle later
    chk_mode_two_write: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (reg_wr_i && hit_two) |=>
            second_right_line_input_diff_o ==
            $past(reg_wdata_i[`RT_MODE_BIT]))
        else $error("input two mode does not follow write");

    // Attenuation equals code times 1.5 dB when connected
    chk_atten_scale_one: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        first_right_line_input_connect_o |->
            first_right_line_input_atten_o ==
            5'({1'b0, $past(level[0])} * `RT_ATTEN_PER_CODE))
        else $error("input one attenuation wrong");

    // Valid code connects input two within one cycle
    chk_valid_connects: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (level[1] <= `RT_LEVEL_MAX) |=>
            second_right_line_input_connect_o)
        else $error("valid code did not connect input two");

    // Off code keeps input one isolated from its second cycle on, for as long as it stands
    chk_off_isolates: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (level[0] == `RT_LEVEL_OFF) [*2] |->
            !first_right_line_input_connect_o &&
            first_right_line_input_atten_o == `RT_ATTEN_NONE)
        else $error("off code left input one connected");

    // Power bit reaches the channel one cycle after the write
    chk_power_write: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (reg_wr_i && hit_one) |=>
            right_adc_power_up_o == $past(reg_wdata_i[`RT_POWER_BIT]))
        else $error("power bit does not follow write");

    // Full-rate stepping answers every tick one cycle later
    chk_step_full_rate: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (sample_tick_i && line_one_q[`RT_STEP_MSB:`RT_STEP_LSB] ==
            STEP_EVERY_SAMPLE) |=> gain_stage_step_o)
        else $error("missed step at full rate");

    // Disabled stepping never steps
    chk_step_disabled: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        line_one_q[`RT_STEP_MSB] |=>
            !gain_stage_step_o && gain_stage_soft_step_off_o)
        else $error("step while soft-stepping disabled");

    // Halved rate never steps on two ticks in a row
    chk_step_half_rate: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (line_one_q[`RT_STEP_MSB:`RT_STEP_LSB] == STEP_EVERY_TWO &&
            $stable(line_one_q) && sample_tick_i && gain_stage_step_o)
            |=> !gain_stage_step_o)
        else $error("halved rate stepped on consecutive ticks");

    // Bias bit follows a write one cycle later
    chk_bias_write: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (reg_wr_i && hit_two) |=>
            unselected_bias_o == $past(reg_wdata_i[`RT_BIAS_BIT]))
        else $error("bias bit does not follow write");

    // Reserved low bits of the second register read as zero
    chk_ro_bits_zero: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (reg_rd_i && hit_two) |=>
            reg_rdata_o[`RT_STEP_MSB:`RT_STEP_LSB] ==
            `RT_LINE_TWO_RO_ZERO)
        else $error("read-only bits not zero");

    // A write to the first register followed by a read returns the written byte
    chk_readback_one: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (reg_wr_i && hit_one) ##1 (reg_rd_i && hit_one && !reg_wr_i)
            |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("readback differs from written value");

    // Attenuation of input two equals code times 1.5 dB
    chk_atten_scale_two: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        second_right_line_input_connect_o |->
            second_right_line_input_atten_o ==
            5'({1'b0, $past(level[1])} * `RT_ATTEN_PER_CODE))
        else $error("input two attenuation wrong");

    // Valid code connects input one within one cycle
    chk_valid_connects_one: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (level[0] <= `RT_LEVEL_MAX) |=>
            first_right_line_input_connect_o)
        else $error("valid code did not connect input one");

    // Off code keeps input two isolated from its second cycle on, for as long as it stands
    chk_off_isolates_two: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (level[1] == `RT_LEVEL_OFF) [*2] |->
            !second_right_line_input_connect_o &&
            second_right_line_input_atten_o == `RT_ATTEN_NONE)
        else $error("off code left input two connected");

    // Gain and open codes never raise the reserved-code flag
    chk_reserved_quiet: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ((level[0] <= `RT_LEVEL_MAX || level[0] == `RT_LEVEL_OFF) &&
            (level[1] <= `RT_LEVEL_MAX || level[1] == `RT_LEVEL_OFF))
            |=> !level_reserved_o)
        else $error("reserved flag raised by a valid code");

    // A step only ever answers a tick of the cycle before
    chk_step_needs_tick: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !sample_tick_i |=> !gain_stage_step_o)
        else $error("step without a sample tick");

    // Write then read of the second register gives the stored byte
    chk_readback_two: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (reg_wr_i && hit_two) ##1 (reg_rd_i && hit_two && !reg_wr_i)
            |=> reg_rdata_o ==
            ($past(reg_wdata_i, 2) & `RT_LINE_TWO_WR_MASK))
        else $error("second register readback differs");

endmodule // right_adc_route_regs

// *** bench/route_host_model.sv ***
`timescale 1ns/1ps
`include "right_route_defs.svh"

module route_host_model (
    input wire logic ref_clk_i,
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i
);
    // ==========================================================
    // Idle bus: strobes low, address and data parked
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end

    // ==========================================================
    // One-cycle write; raw lets a test break the zero-fill habit
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data,
                             input bit raw);
        logic [7:0] wd;
        wd = data;
        // Unless raw, never set the read-only low bits of the second register
        if (!raw && addr == `RT_ADDR_LINE_TWO) begin
            wd[1:0] = 2'b00;
        end
        // Unless raw, reserved level codes are never sent; the open code goes instead
        if (!raw && wd[6:3] > `RT_LEVEL_MAX && wd[6:3] != `RT_LEVEL_OFF) begin
            wd[6:3] = `RT_LEVEL_OFF;
        end
        @(posedge ref_clk_i);
        #1;
        reg_addr_o = addr;
        reg_wdata_o = wd;
        reg_wr_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        reg_wr_o = 1'b0;
        // Released lines must not look like the last value
        reg_addr_o = ~addr;
        reg_wdata_o = ~wd;
    endtask

    // One-cycle read; answer taken just after the edge that takes it
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge ref_clk_i);
        #1;
        reg_addr_o = addr;
        reg_rd_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        data = reg_rdata_i;
        reg_rd_o = 1'b0;
        reg_addr_o = ~addr;
    endtask

    // Write, then read the same place in the very next cycle
    task automatic write_read(input logic [7:0] addr, input logic [7:0] data,
                              output logic [7:0] rdata);
        @(posedge ref_clk_i);
        #1;
        reg_addr_o = addr;
        reg_wdata_o = data;
        reg_wr_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        rdata = reg_rdata_i;
        reg_rd_o = 1'b0;
        reg_addr_o = ~addr;
        reg_wdata_o = ~data;
    endtask
    // Only one right-channel link is modelled, so the mode of a
    // shared input is never set differently on the other side
    // Level codes passed in by tests stay in 0000-1000 or 1111
endmodule // route_host_model

// *** bench/tb_right_adc_input_routing_regs.sv ***
`timescale 1ns/1ps
`include "right_route_defs.svh"

module tb_right_adc_input_routing_regs;
    logic ref_clk_i;
    logic rst_n_i;
    logic sample_tick_i;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic diff1, diff2, conn1, conn2, lvl_res, pwr, bias, step, off;
    logic [4:0] att1, att2;
    logic [7:0] rd;
    logic [7:0] want;
    int bad_count = 0;
    int compares = 0;
    int steps = 0;
    int cycles = 0;

    // ==========================================================
    // Clock, 5 ns period
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    right_adc_route_regs DUT (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
        .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .sample_tick_i(sample_tick_i),
        .first_right_line_input_diff_o(diff1),
        .second_right_line_input_diff_o(diff2),
        .first_right_line_input_connect_o(conn1),
        .second_right_line_input_connect_o(conn2),
        .first_right_line_input_atten_o(att1),
        .second_right_line_input_atten_o(att2),
        .level_reserved_o(lvl_res), .right_adc_power_up_o(pwr),
        .unselected_bias_o(bias), .gain_stage_step_o(step),
        .gain_stage_soft_step_off_o(off)
    );

    route_host_model host (
        .ref_clk_i(ref_clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
        .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata)
    );

    // ==========================================================
    // Step pulses counted every cycle, so a stuck-high pulse shows
    always @(posedge ref_clk_i) begin
        if (step === 1'b1) steps++;
    end

    // Hang guard: whole run is a few hundred cycles
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    // ==========================================================
    // Shared comparison and helpers
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic settle();
        repeat (3) @(posedge ref_clk_i);
        #1;
    endtask

    // Gap 0 holds the tick high for n edges in a row
    task automatic ticks(input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk_i);
            #1 sample_tick_i = 1'b1;
            if (gap > 0) begin
                @(posedge ref_clk_i);
                #1 sample_tick_i = 1'b0;
                repeat (gap - 1) @(posedge ref_clk_i);
            end
        end
        @(posedge ref_clk_i);
        #1 sample_tick_i = 1'b0;
        settle();
    endtask

    task automatic complete_run();
        $display("Counts: %0d compares, %0d bad", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Test sequence
    initial begin
        rst_n_i = 1'b0;
        sample_tick_i = 1'b0;
        repeat (12) @(posedge ref_clk_i);
        #1 rst_n_i = 1'b1;
        settle();

        // Reset state of both registers and their outputs
        host.read_reg(`RT_ADDR_LINE_ONE, rd);
        check(rd, 8'h78);
        host.read_reg(`RT_ADDR_LINE_TWO, rd);
        check(rd, 8'h78);
        check({6'h00, diff1, diff2}, 8'h00);
        check({6'h00, pwr, bias}, 8'h00);
        check({6'h00, conn1, conn2}, 8'h00);
        $display("Test reset_values done");

        // Every valid level code on both inputs, mode/power/bias set
        for (int c = 0; c <= 8; c++) begin
            host.write_reg(`RT_ADDR_LINE_ONE, 8'h84 | (c << 3), 0);
            host.write_reg(`RT_ADDR_LINE_TWO, 8'h84 | (c << 3), 0);
            settle();
            check({7'h00, conn1}, 8'h01);
            check({7'h00, conn2}, 8'h01);
            check({3'h0, att1}, 8'(c * 3));
            check({3'h0, att2}, 8'(c * 3));
            check({4'h0, diff1, diff2, pwr, bias}, 8'h0f);
            check({7'h00, lvl_res}, 8'h00);
            host.read_reg(`RT_ADDR_LINE_ONE, rd);
            check(rd, 8'h84 | (c << 3));
            host.read_reg(`RT_ADDR_LINE_TWO, rd);
            check(rd, 8'h84 | (c << 3));
        end
        $display("Test level_codes done");

        // Open code, single-ended, power and bias off
        host.write_reg(`RT_ADDR_LINE_ONE, 8'h78, 0);
        host.write_reg(`RT_ADDR_LINE_TWO, 8'h78, 0);
        settle();
        check({6'h00, conn1, conn2}, 8'h00);
        check({3'h0, att1}, 8'h00);
        check({3'h0, att2}, 8'h00);
        check({4'h0, diff1, diff2, pwr, bias}, 8'h00);
        $display("Test disconnect done");

        // Low bits of second register refuse a write
        host.write_reg(`RT_ADDR_LINE_TWO, 8'h03, 1);
        host.read_reg(`RT_ADDR_LINE_TWO, rd);
        check(rd, 8'h00);
        check({7'h00, bias}, 8'h00);
        // Unmapped place: read zero, first register untouched
        host.write_reg(8'h18, 8'hff, 0);
        host.read_reg(8'h18, rd);
        check(rd, 8'h00);
        host.read_reg(`RT_ADDR_LINE_ONE, rd);
        check(rd, 8'h78);
        $display("Test refusals done");

        // Back-to-back write and read give the byte just written
        host.write_read(`RT_ADDR_LINE_ONE, 8'ha5, rd);
        check(rd, 8'ha5);
        host.write_read(`RT_ADDR_LINE_TWO, 8'h44, rd);
        check(rd, 8'h44);
        $display("Test back_to_back done");

        // Soft-step rates: 8 ticks, back to back then spaced,
        // give 8, 4, 0, 0 steps
        for (int r = 0; r < 4; r++) begin
            host.write_reg(`RT_ADDR_LINE_ONE, 8'h78 | 8'(r), 0);
            settle();
            check({7'h00, off}, (r >= 2) ? 8'h01 : 8'h00);
            want = (r == 0) ? 8'h08 : (r == 1) ? 8'h04 : 8'h00;
            for (int g = 0; g < 4; g += 3) begin
                steps = 0;
                ticks(8, g);
                check(8'(steps), want);
            end
        end
        $display("Test soft_step done");

        // Reset in mid-run returns every field to its reset value
        host.write_reg(`RT_ADDR_LINE_ONE, 8'h87, 0);
        settle();
        check({4'h0, diff1, pwr, conn1, off}, 8'h0f);
        @(posedge ref_clk_i);
        #1 rst_n_i = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1 rst_n_i = 1'b1;
        settle();
        check({4'h0, diff1, pwr, conn1, off}, 8'h00);
        host.read_reg(`RT_ADDR_LINE_ONE, rd);
        check(rd, 8'h78);
        host.read_reg(`RT_ADDR_LINE_TWO, rd);
        check(rd, 8'h78);
        $display("Test mid_reset done");

        complete_run();
    end
endmodule // tb_right_adc_input_routing_regs
